//--- logic/ntsc_clock.sv
`timescale 1ns/1ps
`include "ntsc_map.svh"
// Overview of operation
// - send a time request to the server; keep the server's answer
// - after each error-free answer, load corrected time into the local time register
// - between updates, advance the time register once every millisecond
// - correction is half of (receive minus send) plus (transmit minus reply)
// - stamp at request send and reply receive; server stamps come in answer
// - after a correction, local time tracks server time within ten milliseconds
// - full accuracy flagged only after two completed server updates
// - polling period is capped at 120 seconds to keep the error bound
// - output is UTC by default, plus zone offset when that option is on
// - daylight saving hour is added inside the configured summer window
// - on server command, repeat one second at the commanded time i_leap_at_ms
// - on server failure, switch over to the other server (primary and backup alternate)
// - correct the clock once per polling period from the reference server
// - time register starts at zero (1980 epoch) and counts until updated
// - status low byte means in sync, high byte means updated once
// - download or server swap reinitialises status; two polls restore it
module ntsc_clock #(
	parameter int unsigned TICK_CYCLES = `NTSC_TICK_CYC
) (
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_reset,
	input  wire logic [7:0]            i_poll_period_s,
	input  wire logic                  i_tz_enable,
	input  wire logic signed [11:0]    i_tz_offset_min,
	input  wire logic                  i_dst_enable,
	input  wire ntsc_pkg::ntsc_time_t  i_dst_begin_ms,
	input  wire ntsc_pkg::ntsc_time_t  i_dst_end_ms,
	input  wire logic                  i_download,
	input  wire logic                  i_resp_valid,
	input  wire logic                  i_resp_error,
	input  wire ntsc_pkg::ntsc_time_t  i_server_receive_stamp,
	input  wire ntsc_pkg::ntsc_time_t  i_server_transmit_stamp,
	input  wire logic                  i_leap_command,
	input  wire ntsc_pkg::ntsc_time_t  i_leap_at_ms,
	output logic                       o_req_send,
	output logic                       o_server_backup,
	output ntsc_pkg::ntsc_time_t       o_utc_ms,
	output ntsc_pkg::ntsc_time_t       o_local_ms,
	output logic [15:0]                o_status,
	output logic                       o_update_pulse,
	output logic                       o_in_leap
);
	ntsc_sync_if sif ();

	logic                       tick;
	ntsc_pkg::ntsc_state_t      state_r;
	ntsc_pkg::ntsc_state_t      state_nxt;
	logic                       req_r;
	logic                       req_nxt;
	logic                       start_r;
	logic                       start_nxt;
	ntsc_pkg::ntsc_time_t       t1_r;
	ntsc_pkg::ntsc_time_t       t1_nxt;
	ntsc_pkg::ntsc_time_t       t2_r;
	ntsc_pkg::ntsc_time_t       t2_nxt;
	ntsc_pkg::ntsc_time_t       t3_r;
	ntsc_pkg::ntsc_time_t       t3_nxt;
	ntsc_pkg::ntsc_time_t       t4_r;
	ntsc_pkg::ntsc_time_t       t4_nxt;
	logic [`NTSC_WAIT_W-1:0]    wait_r;
	logic [`NTSC_WAIT_W-1:0]    wait_nxt;
	logic                       backup_r;
	logic                       backup_nxt;
	logic                       fail;
	logic [7:0]                 period_s;
	logic [`NTSC_POLL_W-1:0]    poll_limit;
	logic [`NTSC_POLL_W-1:0]    poll_r;
	logic [`NTSC_POLL_W-1:0]    poll_nxt;
	logic                       due_r;
	logic                       due_nxt;
	logic                       missed;
	ntsc_pkg::ntsc_time_t       time_r;
	ntsc_pkg::ntsc_time_t       time_nxt;
	logic [`NTSC_LEAP_W-1:0]    leap_r;
	logic [`NTSC_LEAP_W-1:0]    leap_nxt;
	logic                       armed_r;
	logic                       armed_nxt;
	logic                       leap_start;
	logic                       in_leap_r;
	logic                       in_leap_nxt;
	logic                       upd_r;
	logic [1:0]                 updates_r;
	logic [1:0]                 updates_nxt;
	logic                       sync_r;
	logic                       sync_nxt;
	logic [15:0]                status_r;
	logic [15:0]                status_nxt;
	ntsc_pkg::ntsc_time_t       local_r;
	ntsc_pkg::ntsc_time_t       local_nxt;
	ntsc_pkg::ntsc_ofs_t        tz_ofs;

	ntsc_ms_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.o_tick    (tick)
	);

	ntsc_offset_calc u_calc (
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.sif       (sif.calc)
	);

	assign sif.start = start_r;
	assign sif.t1 = t1_r;
	assign sif.t2 = t2_r;
	assign sif.t3 = t3_r;
	assign sif.t4 = t4_r;

	// poll scheduling; zero period would poll only every 2^17 ticks, so clamp both ends
	always_comb begin
		period_s = i_poll_period_s;
		if (period_s < `NTSC_POLL_MIN_S) begin
			period_s = `NTSC_POLL_MIN_S;
		end else if (period_s > `NTSC_POLL_MAX_S) begin
			period_s = `NTSC_POLL_MAX_S;
		end
		poll_limit = `NTSC_POLL_W'({9'h000, period_s}) * `NTSC_POLL_W'(`NTSC_SEC_MS);
		poll_nxt = poll_r;
		due_nxt = due_r;
		missed = 1'b0;
		// clear first, so a period that expires while a request goes out still schedules the next one
		if (state_r == ntsc_pkg::ST_SEND) begin
			due_nxt = 1'b0;
		end
		if (tick) begin
			poll_nxt = poll_r + `NTSC_POLL_W'(1);
			if (poll_r >= poll_limit - `NTSC_POLL_W'(1)) begin
				poll_nxt = '0;
				missed = due_nxt;
				due_nxt = 1'b1;
			end
		end
		if (fail) begin
			due_nxt = 1'b1; // retry at once on the other server
		end
	end

	// request / answer sequencing
	always_comb begin
		state_nxt = state_r;
		req_nxt = 1'b0;
		start_nxt = 1'b0;
		t1_nxt = t1_r;
		t2_nxt = t2_r;
		t3_nxt = t3_r;
		t4_nxt = t4_r;
		wait_nxt = wait_r;
		backup_nxt = backup_r;
		fail = 1'b0;
		unique case (state_r)
			ntsc_pkg::ST_IDLE: begin
				if (due_r) begin
					state_nxt = ntsc_pkg::ST_SEND;
				end
			end
			ntsc_pkg::ST_SEND: begin
				req_nxt = 1'b1;
				t1_nxt = time_r;
				wait_nxt = '0;
				state_nxt = ntsc_pkg::ST_WAIT;
			end
			ntsc_pkg::ST_WAIT: begin
				if (i_resp_valid && !i_resp_error) begin
					t2_nxt = i_server_receive_stamp;
					t3_nxt = i_server_transmit_stamp;
					t4_nxt = time_r;
					start_nxt = 1'b1;
					state_nxt = ntsc_pkg::ST_CALC;
				end else if (i_resp_error || wait_r == `NTSC_RESP_TIMEOUT_MS) begin
					fail = 1'b1;
					backup_nxt = !backup_r;
					state_nxt = ntsc_pkg::ST_IDLE;
				end else if (tick) begin
					wait_nxt = wait_r + `NTSC_WAIT_W'(1);
				end
			end
			ntsc_pkg::ST_CALC: begin
				if (sif.done) begin
					state_nxt = ntsc_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// time register, leap second and correction load
	always_comb begin
		time_nxt = time_r;
		leap_nxt = leap_r;
		armed_nxt = armed_r;
		leap_start = armed_r && tick && leap_r == '0 && time_r == i_leap_at_ms;
		if (tick) begin
			if (leap_r != '0) begin
				leap_nxt = leap_r - `NTSC_LEAP_W'(1);
			end else if (leap_start) begin
				leap_nxt = `NTSC_LEAP_MS - `NTSC_LEAP_W'(1);
				armed_nxt = 1'b0;
			end else begin
				time_nxt = time_r + ntsc_pkg::ntsc_time_t'(1);
			end
		end
		// a fresh command arriving as an older one fires must stay armed, so the set comes last
		if (state_r == ntsc_pkg::ST_WAIT && i_resp_valid && !i_resp_error && i_leap_command) begin
			armed_nxt = 1'b1;
		end
		if (sif.done) begin
			time_nxt = ntsc_pkg::ntsc_add(time_nxt, sif.offset);
		end
		in_leap_nxt = leap_nxt != '0;
	end

	// status word; a swap or a download drops back to uninitialised
	always_comb begin
		updates_nxt = updates_r;
		sync_nxt = sync_r;
		if (fail || i_download) begin
			updates_nxt = 2'h0;
			sync_nxt = 1'b0;
		end else if (sif.done) begin
			if (updates_r != 2'h2) begin
				updates_nxt = updates_r + 2'h1;
			end
			sync_nxt = updates_nxt == 2'h2;
		end else if (missed) begin
			sync_nxt = 1'b0;
		end
		status_nxt = 16'h0000;
		status_nxt[`NTSC_ST_LO_BIT] = sync_nxt;
		status_nxt[`NTSC_ST_HI_BIT] = updates_nxt != 2'h0;
	end

	// local view: zone shift and summer hour added to utc; the summer window compares against utc
	always_comb begin
		tz_ofs = 49'(i_tz_offset_min) * 49'(`NTSC_MIN_MS);
		local_nxt = time_r;
		if (i_tz_enable) begin
			local_nxt = ntsc_pkg::ntsc_add(local_nxt, tz_ofs);
		end
		if (i_dst_enable && time_r >= i_dst_begin_ms && time_r < i_dst_end_ms) begin
			local_nxt = ntsc_pkg::ntsc_add(local_nxt, 49'(`NTSC_DST_MS));
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			state_r <= ntsc_pkg::ST_IDLE;
			req_r <= 1'b0;
			start_r <= 1'b0;
			t1_r <= '0;
			t2_r <= '0;
			t3_r <= '0;
			t4_r <= '0;
			wait_r <= '0;
			backup_r <= 1'b0;
			poll_r <= '0;
			due_r <= 1'b1;
			time_r <= `NTSC_EPOCH_MS;
			leap_r <= '0;
			armed_r <= 1'b0;
			in_leap_r <= 1'b0;
			upd_r <= 1'b0;
			updates_r <= 2'h0;
			sync_r <= 1'b0;
			status_r <= 16'h0000;
			local_r <= '0;
		end else begin
			state_r <= state_nxt;
			req_r <= req_nxt;
			start_r <= start_nxt;
			t1_r <= t1_nxt;
			t2_r <= t2_nxt;
			t3_r <= t3_nxt;
			t4_r <= t4_nxt;
			wait_r <= wait_nxt;
			backup_r <= backup_nxt;
			poll_r <= poll_nxt;
			due_r <= due_nxt;
			time_r <= time_nxt;
			leap_r <= leap_nxt;
			armed_r <= armed_nxt;
			in_leap_r <= in_leap_nxt;
			upd_r <= sif.done;
			updates_r <= updates_nxt;
			sync_r <= sync_nxt;
			status_r <= status_nxt;
			local_r <= local_nxt;
		end
	end

	assign o_req_send = req_r;
	assign o_server_backup = backup_r;
	assign o_utc_ms = time_r;
	assign o_local_ms = local_r;
	assign o_status = status_r;
	assign o_update_pulse = upd_r;
	assign o_in_leap = in_leap_r;

	AST_REQ_STAMP: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_req_send |-> state_r == ntsc_pkg::ST_WAIT && t1_r == $past(time_r) ##1 !o_req_send)
		else $error("request pulse without send stamp");

	AST_CORR_LOAD: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		sif.done && !tick |=> o_update_pulse && time_r == ntsc_pkg::ntsc_add($past(time_r), $past(sif.offset)))
		else $error("correction not loaded into time register");

	AST_MS_ADVANCE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		tick && !sif.done && leap_r == '0 && !leap_start |=> time_r == $past(time_r) + ntsc_pkg::ntsc_time_t'(1))
		else $error("time register did not advance on tick");

	AST_HOLD_NO_TICK: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		!tick && !sif.done |=> $stable(time_r))
		else $error("time register moved without tick");

	AST_LEAP_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		leap_start |=> o_in_leap && leap_r == `NTSC_LEAP_MS - `NTSC_LEAP_W'(1) && $stable(time_r))
		else $error("leap second not started");

	AST_FULL_AFTER_TWO: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_status[`NTSC_ST_LO_BIT] |-> o_status[`NTSC_ST_HI_BIT] && updates_r == 2'h2)
		else $error("in-sync shown before two updates");

	AST_FAILOVER: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		fail |=> o_server_backup != $past(o_server_backup) && o_status == 16'h0000 ##1 state_r == ntsc_pkg::ST_SEND)
		else $error("server swap not performed");

	AST_UTC_DEFAULT: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		!i_tz_enable && !i_dst_enable |=> o_local_ms == $past(o_utc_ms))
		else $error("local time differs from utc with options off");

	AST_POLL_CAP: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		poll_limit <= `NTSC_POLL_W'(`NTSC_POLL_MAX_S) * `NTSC_POLL_W'(`NTSC_SEC_MS) && poll_r < poll_limit)
		else $error("polling period beyond cap");
endmodule

//--- logic/ntsc_ms_tick.sv
`timescale 1ns/1ps
`include "ntsc_map.svh"
module ntsc_ms_tick #(
	parameter int unsigned TICK_CYCLES = `NTSC_TICK_CYC
) (
	input  wire logic i_sys_clk,
	input  wire logic i_reset,
	output logic      o_tick
);
	logic [`NTSC_PRESC_W-1:0] cnt_r;
	logic [`NTSC_PRESC_W-1:0] cnt_nxt;
	logic                     tick_r;
	logic                     tick_nxt;

	always_comb begin
		cnt_nxt = cnt_r + `NTSC_PRESC_W'(1);
		tick_nxt = 1'b0;
		if (cnt_r == `NTSC_PRESC_W'(TICK_CYCLES - 1)) begin
			cnt_nxt = '0;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign o_tick = tick_r;

	AST_TICK_SPACING: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_tick |-> cnt_r == '0 ##1 !o_tick)
		else $error("tick not followed by prescaler restart");
endmodule

//--- logic/ntsc_offset_calc.sv
`timescale 1ns/1ps
module ntsc_offset_calc (
	input  wire logic i_sys_clk,
	input  wire logic i_reset,
	ntsc_sync_if.calc sif
);
	ntsc_pkg::ntsc_ofs_t offset_r;
	ntsc_pkg::ntsc_ofs_t offset_nxt;
	logic                done_r;
	logic signed [49:0]  sum;

	function automatic ntsc_pkg::ntsc_ofs_t f_diff(input ntsc_pkg::ntsc_time_t a, input ntsc_pkg::ntsc_time_t b);
		return $signed({1'b0, a}) - $signed({1'b0, b});
	endfunction

	always_comb begin
		sum = 50'(f_diff(sif.t2, sif.t1)) + 50'(f_diff(sif.t3, sif.t4));
		offset_nxt = offset_r;
		if (sif.start) begin
			offset_nxt = 49'(sum >>> 1);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			offset_r <= '0;
			done_r <= 1'b0;
		end else begin
			offset_r <= offset_nxt;
			done_r <= sif.start;
		end
	end

	assign sif.offset = offset_r;
	assign sif.done = done_r;

	AST_OFFSET_HALF_SUM: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		sif.start |=> sif.done && (sif.offset == 49'($past(sum) >>> 1)))
		else $error("offset is not half the stamp difference sum");
endmodule

//--- shared/ntsc_map.svh
`ifndef NTSC_MAP_SVH
`define NTSC_MAP_SVH
`define NTSC_TIME_W          48
`define NTSC_EPOCH_MS        48'h0
`define NTSC_CLK_PERIOD_NS   10
`define NTSC_TICK_PERIOD_NS  1000000
`define NTSC_TICK_CYC        (`NTSC_TICK_PERIOD_NS / `NTSC_CLK_PERIOD_NS)
`define NTSC_PRESC_W         17
`define NTSC_POLL_W          17
`define NTSC_POLL_MIN_S      8'h01
`define NTSC_POLL_MAX_S      8'h78
`define NTSC_SEC_MS          1000
`define NTSC_MIN_MS          60000
`define NTSC_DST_MS          3600000
`define NTSC_WAIT_W          10
`define NTSC_RESP_TIMEOUT_MS 10'h3E8
`define NTSC_LEAP_W          10
`define NTSC_LEAP_MS         10'h3E8
`define NTSC_ST_LO_BIT       0
`define NTSC_ST_HI_BIT       8
`endif

//--- shared/ntsc_pkg.sv
package ntsc_pkg;
`include "ntsc_map.svh"
	typedef logic [`NTSC_TIME_W-1:0] ntsc_time_t;
	typedef logic signed [`NTSC_TIME_W:0] ntsc_ofs_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_SEND = 2'h1,
		ST_WAIT = 2'h3,
		ST_CALC = 2'h2
	} ntsc_state_t;

	// wraps modulo 2^48, so negative offsets need no special case
	function automatic ntsc_time_t ntsc_add(input ntsc_time_t t, input ntsc_ofs_t d);
		return t + ntsc_time_t'(d);
	endfunction
endpackage

//--- shared/ntsc_sync_if.sv
`timescale 1ns/1ps
interface ntsc_sync_if;
	logic                start;
	ntsc_pkg::ntsc_time_t t1;
	ntsc_pkg::ntsc_time_t t2;
	ntsc_pkg::ntsc_time_t t3;
	ntsc_pkg::ntsc_time_t t4;
	ntsc_pkg::ntsc_ofs_t  offset;
	logic                done;
	modport ctrl (output start, output t1, output t2, output t3, output t4, input offset, input done);
	modport calc (input start, input t1, input t2, input t3, input t4, output offset, output done);
endinterface

//--- testbench/ntsc_server_model.sv
`timescale 1ns/1ps
module ntsc_server_model #(
	parameter int unsigned TICK_CYCLES = 10
) (
	input  wire logic                i_sys_clk,
	input  wire logic                i_reset,
	input  wire logic                i_req,
	input  wire logic [7:0]          i_delay,
	input  wire logic                i_fail,
	input  wire logic                i_leap,
	input  wire ntsc_pkg::ntsc_ofs_t i_shift,
	output logic                     o_resp_valid,
	output logic                     o_resp_error,
	output logic                     o_leap_cmd,
	output ntsc_pkg::ntsc_time_t     o_rx_stamp,
	output ntsc_pkg::ntsc_time_t     o_tx_stamp
);
	// one model serves primary and backup, so both share one time base
	int unsigned          presc_r;
	ntsc_pkg::ntsc_time_t ms_r;
	ntsc_pkg::ntsc_time_t rx_r;
	logic [7:0]           wait_r;
	logic                 busy_r;
	ntsc_pkg::ntsc_time_t now;

	assign now = ms_r + ntsc_pkg::ntsc_time_t'(i_shift);

	always_ff @(posedge i_sys_clk) begin
		o_resp_valid <= 1'b0;
		o_resp_error <= 1'b0;
		o_leap_cmd   <= 1'b0;
		// stamps are only meaningful with valid; toggle so stale values never look good
		o_rx_stamp   <= ~o_rx_stamp;
		o_tx_stamp   <= ~o_tx_stamp;
		if (i_reset) begin
			presc_r    <= 0;
			ms_r       <= '0;
			busy_r     <= 1'b0;
			wait_r     <= 8'h00;
			o_rx_stamp <= '0;
			o_tx_stamp <= '0;
		end else begin
			presc_r <= (presc_r == TICK_CYCLES - 1) ? 0 : presc_r + 1;
			if (presc_r == TICK_CYCLES - 1) begin
				ms_r <= ms_r + 48'h1;
			end
			if (i_req && !busy_r) begin
				busy_r <= 1'b1;
				wait_r <= i_delay;
				rx_r   <= now;
			end else if (busy_r) begin
				if (wait_r <= 8'h01) begin
					busy_r       <= 1'b0;
					o_resp_valid <= 1'b1;
					o_resp_error <= i_fail;
					o_leap_cmd   <= i_leap;
					o_rx_stamp   <= rx_r;
					o_tx_stamp   <= now;
				end else begin
					wait_r <= wait_r - 8'h01;
				end
			end
		end
	end
endmodule

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	typedef struct {
		ntsc_pkg::ntsc_ofs_t shift;
		logic [7:0]          delay;
		logic                tz_en;
		logic signed [11:0]  tz_min;
		logic                dst_en;
		logic [15:0]         status;
	} ntsc_row_t;
	ntsc_row_t rows [5] = '{
		'{49'sh1388, 8'h03, 1'b0, 12'sh0, 1'b0, 16'h0100},
		'{-49'sh7D0, 8'h14, 1'b1, 12'sh3C, 1'b0, 16'h0101},
		'{49'sh0, 8'h01, 1'b1, -12'sh5A, 1'b1, 16'h0101},
		'{49'sh1E241, 8'h28, 1'b0, 12'sh0, 1'b1, 16'h0101},
		'{-49'sh7, 8'h19, 1'b1, -12'sh2D0, 1'b0, 16'h0101}};
	logic                  i_sys_clk, i_reset, i_tz_enable, i_dst_enable, i_download;
	logic [7:0]            i_poll_period_s, delay;
	logic signed [11:0]    i_tz_offset_min;
	ntsc_pkg::ntsc_time_t  i_leap_at_ms, o_utc_ms, o_local_ms, srv_rx, srv_tx;
	ntsc_pkg::ntsc_time_t  prev_utc, t1, t2, t3, t4, a, d, dst_begin, dst_end;
	ntsc_pkg::ntsc_ofs_t   shift;
	logic                  fail, leap, srv_valid, srv_error, srv_leap;
	logic                  o_req_send, o_server_backup, o_update_pulse, o_in_leap;
	logic [15:0]           o_status;
	longint                off;
	int                    err_count = 0;
	int                    n_checks = 0;

	ntsc_clock #(.TICK_CYCLES(10)) dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
		.i_poll_period_s(i_poll_period_s), .i_tz_enable(i_tz_enable), .i_tz_offset_min(i_tz_offset_min),
		.i_dst_enable(i_dst_enable), .i_dst_begin_ms(dst_begin), .i_dst_end_ms(dst_end),
		.i_download(i_download), .i_resp_valid(srv_valid), .i_resp_error(srv_error),
		.i_server_receive_stamp(srv_rx), .i_server_transmit_stamp(srv_tx), .i_leap_command(srv_leap),
		.i_leap_at_ms(i_leap_at_ms), .o_req_send(o_req_send), .o_server_backup(o_server_backup),
		.o_utc_ms(o_utc_ms), .o_local_ms(o_local_ms), .o_status(o_status),
		.o_update_pulse(o_update_pulse), .o_in_leap(o_in_leap));

	ntsc_server_model #(.TICK_CYCLES(10)) srv (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_req(o_req_send),
		.i_delay(delay), .i_fail(fail), .i_leap(leap), .i_shift(shift), .o_resp_valid(srv_valid),
		.o_resp_error(srv_error), .o_leap_cmd(srv_leap), .o_rx_stamp(srv_rx), .o_tx_stamp(srv_tx));

	// stamps as the design should see them: send stamp from the cycle before the request
	always @(posedge i_sys_clk) begin
		prev_utc <= o_utc_ms;
		if (o_req_send) t1 <= prev_utc;
		if (srv_valid && !srv_error) begin
			t2 <= srv_rx;
			t3 <= srv_tx;
			t4 <= o_utc_ms;
		end
	end

	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input ntsc_pkg::ntsc_time_t got, input ntsc_pkg::ntsc_time_t exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic wait_flag(input int sel, input int lim);
		logic f;
		for (int k = 0; k < lim; k++) begin
			@(negedge i_sys_clk);
			f = (sel == 0) ? o_req_send : (sel == 1) ? o_update_pulse : (sel == 2) ? o_in_leap : srv_valid;
			if (f === 1'b1) return;
		end
		err_count++;
		$display("wrong value at %0t: wait timed out", $time);
		wrap_up();
	endtask

	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	initial begin
		i_reset = 1'b1; i_poll_period_s = 8'h01; i_tz_enable = 1'b0; i_tz_offset_min = 12'sh0;
		i_dst_enable = 1'b0; i_download = 1'b0; i_leap_at_ms = 48'hFFFFFFFFFFFF;
		dst_begin = 48'h0;
		dst_end = 48'hFFFFFFFFFFFF;
		delay = 8'h03; fail = 1'b0; leap = 1'b0; shift = '0;
		@(posedge i_sys_clk);
		@(negedge i_sys_clk);
		chk(o_utc_ms, 48'h0, "time in reset");
		chk(48'(o_status), 48'h0, "status in reset");
		@(posedge i_sys_clk) i_reset <= 1'b0;
		foreach (rows[i]) begin
			@(posedge i_sys_clk);
			shift <= rows[i].shift; delay <= rows[i].delay; i_tz_enable <= rows[i].tz_en;
			i_tz_offset_min <= rows[i].tz_min; i_dst_enable <= rows[i].dst_en;
			wait_flag(0, 12000);
			wait_flag(1, 400);
			off = ((longint'(t2) - longint'(t1)) + (longint'(t3) - longint'(t4))) >>> 1;
			d = o_utc_ms - (t4 + ntsc_pkg::ntsc_time_t'(off));
			chk(48'(d > 48'h1), 48'h0, "corrected time");
			chk(48'(o_status), 48'(rows[i].status), "status after update");
			chk(o_local_ms, prev_utc + ntsc_pkg::ntsc_time_t'(rows[i].tz_en ? longint'(rows[i].tz_min) *
				64'shEA60 : 64'sh0) + (rows[i].dst_en ? 48'h36EE80 : 48'h0), "local time");
			a = o_utc_ms;
			repeat (100) @(negedge i_sys_clk);
			chk(o_utc_ms - a, 48'hA, "tick rate");
		end
		// failing server: backup takes over and status restarts
		@(posedge i_sys_clk) fail <= 1'b1;
		wait_flag(0, 12000);
		wait_flag(3, 300);
		@(posedge i_sys_clk) fail <= 1'b0;
		wait_flag(0, 20);
		chk(48'(o_server_backup), 48'h1, "backup selected");
		chk(48'(o_status), 48'h0, "status after swap");
		wait_flag(1, 400);
		chk(48'(o_status), 48'h100, "status after first update");
		@(posedge i_sys_clk) i_download <= 1'b1;
		@(posedge i_sys_clk) i_download <= 1'b0;
		@(negedge i_sys_clk);
		chk(48'(o_status), 48'h0, "status after download");
		// arm at the one-second poll; the long period then keeps corrections out of the held second
		@(posedge i_sys_clk) leap <= 1'b1;
		wait_flag(0, 12000);
		wait_flag(1, 400);
		@(posedge i_sys_clk);
		leap <= 1'b0;
		i_poll_period_s <= 8'hC8;
		i_leap_at_ms <= o_utc_ms + 48'h14;
		wait_flag(2, 400);
		a = o_utc_ms;
		repeat (9000) @(negedge i_sys_clk);
		chk(o_utc_ms, a, "time held in leap second");
		chk(48'(o_in_leap), 48'h1, "leap flag");
		repeat (1200) @(negedge i_sys_clk);
		chk(48'(o_in_leap), 48'h0, "leap flag cleared");
		chk(48'(o_utc_ms == a), 48'h0, "time resumes");
		// summer hour only inside its utc window
		@(posedge i_sys_clk);
		i_tz_enable <= 1'b0;
		i_dst_enable <= 1'b1;
		dst_begin <= o_utc_ms + 48'h5;
		dst_end <= o_utc_ms + 48'hA;
		repeat (2) @(negedge i_sys_clk);
		chk(o_local_ms, prev_utc, "local before summer window");
		repeat (60) @(negedge i_sys_clk);
		chk(o_local_ms, prev_utc + 48'h36EE80, "local inside summer window");
		repeat (60) @(negedge i_sys_clk);
		chk(o_local_ms, prev_utc, "local after summer window");
		// reset in mid-run: power-up view again, primary server, and a poll due at once
		@(posedge i_sys_clk) i_reset <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		@(negedge i_sys_clk);
		chk(o_utc_ms, 48'h0, "time after mid-run reset");
		chk(48'(o_status), 48'h0, "status after mid-run reset");
		chk(48'(o_server_backup), 48'h0, "primary after mid-run reset");
		wait_flag(0, 4);
		wrap_up();
	end
endmodule
